// ---- verilog/spme_core.sv ----
// device side serial program/verify port with mode entry
`include "spme_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module spme_core (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // entry pins
  input wire logic i_master_clear_hv,
  input wire logic i_low_voltage_prog_select_pin,
  // serial port pins
  input wire logic i_prog_clock_pin,
  input wire logic i_prog_data_pin,
  output logic o_prog_data_pin,
  output logic o_prog_data_oe,
  // nonvolatile configuration and memory read data
  input wire logic i_low_voltage_prog_enable,
  input wire logic [`SPME_DATA_BITS-1:0] i_mem_rdata,
  // memory write stream
  output logic o_wr_valid,
  output logic [`SPME_DATA_BITS-1:0] o_wr_data,
  input wire logic i_wr_ready,
  output logic [`SPME_PC_BITS-1:0] o_pc,
  output logic o_bulk_erase,
  output logic o_lvp_write_refused,
  // mode status
  output logic o_prog_mode,
  output logic o_gpio_select_free,
  output spme_pkg::spme_entry_t o_entry_kind
);
  import spme_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [1:0] hv_sync_reg, sel_sync_reg, clk_sync_reg, dat_sync_reg;
  logic clk_prev_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      hv_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
      clk_sync_reg <= 2'h0;
      dat_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      hv_sync_reg <= {hv_sync_reg[0], i_master_clear_hv};
      sel_sync_reg <= {sel_sync_reg[0], i_low_voltage_prog_select_pin};
      clk_sync_reg <= {clk_sync_reg[0], i_prog_clock_pin};
      dat_sync_reg <= {dat_sync_reg[0], i_prog_data_pin};
      clk_prev_reg <= clk_sync_reg[1];
    end
  end
  logic hv_s, sel_s, clk_s, dat_s, clk_fall, clk_rise;
  assign hv_s = hv_sync_reg[1];
  assign sel_s = sel_sync_reg[1];
  assign clk_s = clk_sync_reg[1];
  assign dat_s = dat_sync_reg[1];
  assign clk_fall = clk_prev_reg && !clk_s;
  assign clk_rise = !clk_prev_reg && clk_s;

  // ==========================================================
  // mode entry
  logic lv_req, hv_req, entry_ok;
  spme_entry_t entry_reg;
  assign lv_req = i_low_voltage_prog_enable && sel_s;
  assign hv_req = hv_s;
  // entry only while clock and data idle low
  assign entry_ok = !clk_s && !dat_s;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      entry_reg <= SPME_ENTRY_NONE;
    end else if (!hv_req && !lv_req) begin
      entry_reg <= SPME_ENTRY_NONE;
    end else if (entry_reg == SPME_ENTRY_NONE && entry_ok) begin
      entry_reg <= hv_req ? SPME_ENTRY_HV : SPME_ENTRY_LV;
    end
  end
  logic in_mode;
  assign in_mode = (entry_reg != SPME_ENTRY_NONE);
  assign o_prog_mode = in_mode;
  assign o_entry_kind = entry_reg;
  assign o_gpio_select_free = !i_low_voltage_prog_enable;

  // ==========================================================
  // serial shift engine
  spme_state_t state_reg;
  logic [`SPME_DATA_BITS-1:0] shift_reg;
  logic [4:0] bit_reg;
  logic [`SPME_CMD_BITS-1:0] cmd_reg;
  logic [`SPME_PC_BITS-1:0] pc_reg;
  logic load_done, erase_reg, refuse_reg;
  assign load_done = (state_reg == SPME_LOAD) && clk_fall &&
    (bit_reg == 5'(`SPME_DATA_BITS - 1));
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !in_mode) begin
      state_reg <= SPME_IDLE;
      bit_reg <= 5'h00;
      shift_reg <= '0;
      cmd_reg <= '0;
    end else begin
      case (state_reg)
        SPME_IDLE: begin
          state_reg <= SPME_CMD;
          bit_reg <= 5'h00;
        end
        SPME_CMD: begin
          if (clk_fall) begin
            cmd_reg <= {dat_s, cmd_reg[`SPME_CMD_BITS-1:1]};
            bit_reg <= bit_reg + 5'h01;
            if (bit_reg == 5'(`SPME_CMD_BITS - 1)) begin
              state_reg <= SPME_DECODE;
            end
          end
        end
        SPME_DECODE: begin
          bit_reg <= 5'h00;
          if (cmd_reg == `SPME_CMD_LOAD_CFG ||
              cmd_reg == `SPME_CMD_LOAD_PROG) begin
            state_reg <= SPME_LOAD;
          end else if (cmd_reg == `SPME_CMD_READ_PROG) begin
            state_reg <= SPME_READ;
            shift_reg <= uid_mask(pc_reg, i_mem_rdata);
          end else begin
            state_reg <= SPME_CMD;
          end
        end
        SPME_LOAD: begin
          if (clk_fall) begin
            shift_reg <= {dat_s, shift_reg[`SPME_DATA_BITS-1:1]};
            bit_reg <= bit_reg + 5'h01;
            if (load_done) begin
              state_reg <= SPME_CMD;
              bit_reg <= 5'h00;
            end
          end
        end
        SPME_READ: begin
          // device presents next bit on rising edge
          if (clk_fall) begin
            shift_reg <= {1'b0, shift_reg[`SPME_DATA_BITS-1:1]};
            bit_reg <= bit_reg + 5'h01;
            if (bit_reg == 5'(`SPME_DATA_BITS - 1)) begin
              state_reg <= SPME_CMD;
              bit_reg <= 5'h00;
            end
          end
        end
        default: begin
          state_reg <= SPME_IDLE;
        end
      endcase
    end
  end

  // user id words keep only their low nibble
  function automatic logic [`SPME_DATA_BITS-1:0] uid_mask(
    input logic [`SPME_PC_BITS-1:0] addr,
    input logic [`SPME_DATA_BITS-1:0] word);
    if (addr[`SPME_PC_BITS-1:2] == 12'(`SPME_UID_BASE >> 2)) begin
      uid_mask = {{(`SPME_DATA_BITS-`SPME_UID_BITS){1'b0}},
        word[`SPME_UID_BITS-1:0]};
    end else begin
      uid_mask = word;
    end
  endfunction

  // program counter
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !in_mode) begin
      pc_reg <= `SPME_PC_RESET;
    end else if (state_reg == SPME_DECODE) begin
      if (cmd_reg == `SPME_CMD_LOAD_CFG) begin
        pc_reg <= `SPME_UID_BASE;
      end else if (cmd_reg == `SPME_CMD_INC_ADDR) begin
        pc_reg <= pc_reg + 14'h0001;
      end
    end
  end
  assign o_pc = pc_reg;

  // erase request and lvp write guard
  logic lvp_touch;
  assign lvp_touch = (pc_reg == `SPME_CFG_ADDR) && load_done &&
    (dat_s != i_low_voltage_prog_enable);
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      erase_reg <= 1'b0;
      refuse_reg <= 1'b0;
    end else begin
      // whole array and eeprom, calibration left alone
      erase_reg <= in_mode && state_reg == SPME_DECODE &&
        cmd_reg == `SPME_CMD_BULK_ERASE;
      refuse_reg <= lvp_touch && entry_reg == SPME_ENTRY_LV;
    end
  end
  assign o_bulk_erase = erase_reg;
  assign o_lvp_write_refused = refuse_reg;

  // ==========================================================
  // write stream fifo, lv session forces lvp bit unchanged
  logic [`SPME_DATA_BITS-1:0] wr_word;
  always_comb begin
    wr_word = {dat_s, shift_reg[`SPME_DATA_BITS-1:1]};
    if (pc_reg == `SPME_CFG_ADDR && entry_reg == SPME_ENTRY_LV) begin
      wr_word[`SPME_LVP_BIT] = i_low_voltage_prog_enable;
    end
    wr_word = uid_mask(pc_reg, wr_word);
  end
  spme_fifo #(.WIDTH(`SPME_DATA_BITS), .DEPTH(`SPME_FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_in_valid(load_done),
    .i_in_data(wr_word),
    .o_in_ready(), // full buffer drops the word
    .o_out_valid(o_wr_valid),
    .o_out_data(o_wr_data),
    .i_out_ready(i_wr_ready)
  );

  // data pin drive during read
  always_ff @(posedge i_core_clk) begin
    if (i_srst || state_reg != SPME_READ) begin
      o_prog_data_pin <= 1'b0;
      o_prog_data_oe <= 1'b0;
    end else if (clk_rise) begin
      o_prog_data_pin <= shift_reg[0];
      o_prog_data_oe <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  sequence s_cmd_done;
    state_reg == SPME_CMD && clk_fall && bit_reg == 5'h05;
  endsequence
  chk_cmd_six_bits: assert property (@(posedge i_core_clk) disable iff
    (i_srst) s_cmd_done |=> state_reg == SPME_DECODE || !in_mode)
    else $error("command not closed after six bits");
  chk_pc_zero_entry: assert property (@(posedge i_core_clk) disable iff
    (i_srst) $rose(in_mode) |-> pc_reg == 14'h0000)
    else $error("pc not zero at entry");
  chk_lv_gate: assert property (@(posedge i_core_clk) disable iff
    (i_srst) $rose(in_mode) && !$past(hv_s) |->
    $past(i_low_voltage_prog_enable))
    else $error("low voltage entry while disabled");
  chk_mode_exit: assert property (@(posedge i_core_clk) disable iff
    (i_srst) in_mode && !hv_s && !lv_req |=> !in_mode)
    else $error("mode held after entry removed");
  chk_hv_kind: assert property (@(posedge i_core_clk) disable iff
    (i_srst) $rose(in_mode) && $past(hv_s) |->
    entry_reg == SPME_ENTRY_HV)
    else $error("high voltage entry misclassified");
  chk_lvp_refuse: assert property (@(posedge i_core_clk) disable iff
    (i_srst) lvp_touch && entry_reg == SPME_ENTRY_LV |=> refuse_reg)
    else $error("lvp change not refused");
  chk_oe_read_only: assert property (@(posedge i_core_clk) disable iff
    (i_srst) o_prog_data_oe |-> $past(state_reg) == SPME_READ)
    else $error("data driven outside read");
  chk_entry_idle: assert property (@(posedge i_core_clk) disable iff
    (i_srst) $rose(in_mode) |-> $past(clk_s) == 1'b0)
    else $error("entry with clock high");
  chk_select_reserved: assert property (@(posedge i_core_clk) disable iff
    (i_srst) i_low_voltage_prog_enable |-> !o_gpio_select_free)
    else $error("select pin released while enabled");
endmodule // spme_core
`default_nettype wire

// ---- common/spme_regs.svh ----
// constants for the serial program mode entry block
`ifndef SPME_REGS_SVH
`define SPME_REGS_SVH
`define SPME_CMD_BITS 6
`define SPME_DATA_BITS 14
`define SPME_UID_BITS 4
`define SPME_PC_BITS 14
`define SPME_PC_RESET 14'h0000
`define SPME_UID_BASE 14'h2000
`define SPME_CFG_ADDR 14'h2007
`define SPME_LVP_BIT 13
`define SPME_FIFO_DEPTH 16
// command codes
`define SPME_CMD_LOAD_CFG 6'h00
`define SPME_CMD_LOAD_PROG 6'h02
`define SPME_CMD_READ_PROG 6'h04
`define SPME_CMD_INC_ADDR 6'h06
`define SPME_CMD_BEGIN_PROG 6'h08
`define SPME_CMD_BULK_ERASE 6'h09
`endif

// ---- common/spme_pkg.sv ----
// types for the serial program mode entry block
package spme_pkg;
  typedef enum logic [2:0] {
    SPME_IDLE = 3'h0,
    SPME_CMD = 3'h1,
    SPME_DECODE = 3'h3,
    SPME_LOAD = 3'h2,
    SPME_READ = 3'h6
  } spme_state_t;
  typedef enum logic [1:0] {
    SPME_ENTRY_NONE = 2'h0,
    SPME_ENTRY_HV = 2'h1,
    SPME_ENTRY_LV = 2'h2
  } spme_entry_t;
endpackage

// ---- verilog/spme_fifo.sv ----
// parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module spme_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  // handshake terms
  assign o_in_ready = (cnt_reg < (AW+1)'(DEPTH)); // room while below depth
  assign o_out_valid = (cnt_reg != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_reg[rd_reg];
  // storage write
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // fifo never overfills or underflows
  chk_fifo_count_bound: assert property (@(posedge i_core_clk)
    disable iff (i_srst) cnt_reg <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule // spme_fifo
`default_nettype wire

// ---- dv/spme_prog_model.sv ----
// programmer model for the serial program port
`timescale 1ns/10ps
`default_nettype none
module spme_prog_model (
  // core clock for pacing
  input wire logic i_core_clk,
  // port pins
  output logic o_clk,
  output logic o_dat,
  output logic o_oe,
  output logic o_hv,
  output logic o_sel,
  input wire logic i_dat
);
  // clock and data parked low while entry pins move
  initial begin
    o_clk = 1'b0;
    o_dat = 1'b0;
    o_oe = 1'b1;
    o_hv = 1'b0;
    o_sel = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // raise or drop the entry pins, then settle
  task automatic enter(input logic hv, input logic sel);
    o_hv = hv;
    o_sel = sel;
    wait_cyc(8);
  endtask
  // lsb first, device samples on the falling edge
  task automatic bits(input int n, input logic [13:0] v);
    for (int i = 0; i < n; i++) begin
      o_oe = 1'b1;
      o_dat = v[i];
      o_clk = 1'b1;
      wait_cyc(4);
      o_clk = 1'b0;
      wait_cyc(4);
    end
    o_dat = 1'b0;
    wait_cyc(4);
  endtask
  task automatic cmd(input logic [5:0] c);
    bits(6, {8'h00, c});
  endtask
  task automatic word(input logic [13:0] w);
    bits(14, w);
  endtask
  // line released, one bit taken before each next rise
  task automatic recv(output logic [13:0] v);
    o_oe = 1'b0;
    for (int i = 0; i < 14; i++) begin
      o_clk = 1'b1;
      wait_cyc(4);
      o_clk = 1'b0;
      wait_cyc(4);
      v[i] = i_dat;
    end
    o_oe = 1'b1;
    wait_cyc(4);
  endtask
endmodule // spme_prog_model
`default_nettype wire

// ---- dv/tb_spme_core.sv ----
// self-checking bench for the program mode entry core
`include "spme_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_spme_core;
  import spme_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic lvp_en = 1'b1;
  logic ready = 1'b0;
  logic fill = 1'b0;
  logic wave_reg = 1'b0;
  logic [15:0] lfsr_reg = 16'h0019;
  logic [15:0] stall_reg = 16'h0019;
  logic [13:0] exp_q[$];
  logic [13:0] rd;
  int mismatches = 0;
  int samples_checked = 0;
  int bulk_cnt = 0;
  int ref_cnt = 0;
  wire logic pclk, pdat, poe, hv, sel, ddat, doe, wv, bulk, refd, mode, gfree;
  wire logic line;
  wire logic [13:0] wdata, pc;
  wire logic [1:0] kind;
  always #2 i_core_clk = ~i_core_clk;
  // released line shows a changing pattern
  always @(posedge i_core_clk) wave_reg <= ~wave_reg;
  assign line = doe ? ddat : (poe ? pdat : wave_reg);
  spme_prog_model spme_prog_model_inst (.i_core_clk(i_core_clk),
    .o_clk(pclk), .o_dat(pdat), .o_oe(poe), .o_hv(hv), .o_sel(sel),
    .i_dat(line));
  spme_core spme_core_inst (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_master_clear_hv(hv), .i_low_voltage_prog_select_pin(sel),
    .i_prog_clock_pin(pclk), .i_prog_data_pin(line),
    .o_prog_data_pin(ddat), .o_prog_data_oe(doe),
    .i_low_voltage_prog_enable(lvp_en), .i_mem_rdata(pc ^ 14'h1a5c),
    .o_wr_valid(wv), .o_wr_data(wdata), .i_wr_ready(ready), .o_pc(pc),
    .o_bulk_erase(bulk), .o_lvp_write_refused(refd), .o_prog_mode(mode),
    .o_gpio_select_free(gfree), .o_entry_kind(kind));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic load(input logic [5:0] c, input logic [13:0] w);
    spme_prog_model_inst.cmd(c);
    spme_prog_model_inst.word(w);
  endtask
  // random stalls on the write stream, ready held low while filling
  always @(negedge i_core_clk) begin
    stall_reg <= lfsr_next(stall_reg);
    ready <= !fill && stall_reg[0];
  end
  // pulse counters and the oldest expected word per write
  always @(posedge i_core_clk) begin
    if (bulk === 1'b1) bulk_cnt++;
    if (refd === 1'b1) ref_cnt++;
    if (wv === 1'b1 && ready === 1'b1) begin
      if (exp_q.size() == 0) check(wdata, 16'hffff);
      else check(wdata, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (5) @(negedge i_core_clk);
    i_srst = 1'b0;
    @(negedge i_core_clk);
    check(mode, 16'h0);
    check(gfree, 16'h0);
    spme_prog_model_inst.enter(1'b1, 1'b0);
    check(mode, 16'h1);
    check(pc, 16'h0);
    check(kind, 16'(SPME_ENTRY_HV));
    // back-to-back random loads, then fill past the buffer depth
    for (int i = 0; i < 21; i++) begin
      // early words drained first so sixteen fill it exactly
      while (i == 4 && wv === 1'b1) @(negedge i_core_clk);
      fill = (i >= 4);
      lfsr_reg = lfsr_next(lfsr_reg);
      if (i < 20) exp_q.push_back(lfsr_reg[13:0]);
      load(`SPME_CMD_LOAD_PROG, lfsr_reg[13:0]);
    end
    fill = 1'b0;
    for (int i = 0; i < 800 && exp_q.size() != 0; i++)
      @(negedge i_core_clk);
    check(exp_q.size(), 16'h0);
    spme_prog_model_inst.cmd(`SPME_CMD_INC_ADDR);
    check(pc, 16'h1);
    spme_prog_model_inst.cmd(`SPME_CMD_READ_PROG);
    spme_prog_model_inst.recv(rd);
    check(rd, 16'h1a5d);
    spme_prog_model_inst.cmd(`SPME_CMD_BULK_ERASE);
    check(bulk_cnt, 16'h1);
    // low voltage session refuses the enable bit, high voltage takes it
    for (int s = 0; s < 2; s++) begin
      spme_prog_model_inst.enter(1'b0, 1'b0);
      check(mode, 16'h0);
      spme_prog_model_inst.enter(s == 1, s == 0);
      check(kind, s == 0 ? 16'h2 : 16'h1);
      exp_q.push_back(14'h000f);
      load(`SPME_CMD_LOAD_CFG, 14'h3fff);
      for (int i = 0; i < 7; i++)
        spme_prog_model_inst.cmd(`SPME_CMD_INC_ADDR);
      check(pc, 16'h2007);
      exp_q.push_back(s == 0 ? 14'h2000 : 14'h0000);
      load(`SPME_CMD_LOAD_PROG, 14'h0000);
      check(ref_cnt, 16'h1);
    end
    // enable cleared: select pin is plain io, only high voltage enters
    lvp_en = 1'b0;
    spme_prog_model_inst.enter(1'b0, 1'b1);
    check(mode, 16'h0);
    check(gfree, 16'h1);
    spme_prog_model_inst.enter(1'b1, 1'b1);
    check(mode, 16'h1);
    check(exp_q.size(), 16'h0);
    stop_test;
  end
endmodule // tb_spme_core
`default_nettype wire
